// ### core/rcr_regs.sv
// Regulator control register bank: memory reference regulator and two linear regulators.
// Assumes power-state inputs, fuse values and sequencer pulses come from logic on i_sys_clk.
// Operation
// RULE1: The memory reference run enable at bit 0 turns that regulator off at 0 and on at 1, and the power-up sequence sets it.
// RULE2: The memory reference standby enable at bit 1 keeps it on in standby only when also the run enable is 1.
// RULE3: The memory reference sleep enable at bit 2 keeps it on in sleep when set and the run enable is 1.
// RULE4: The memory reference low-power bit at 3 selects low-power operation at 1 and normal at 0.
// RULE5: Configuration gives the memory reference standby enable the same default as its run enable.
// RULE6: The first linear regulator voltage register holds a five-bit code in bits 4 to 0 loaded from fuses.
// RULE7: The second linear regulator voltage register holds a four-bit code in bits 3 to 0 loaded from fuses.
// RULE8: Each linear regulator run enable at bit 0 is loaded by the sequence and software writing 0 turns it off.
// RULE9: Each linear regulator standby enable at bit 1 keeps it on in standby at 1 and off at 0.
// RULE10: Each linear regulator sleep enable at bit 2 keeps it on in sleep at 1 and off at 0.
// RULE11: Each linear regulator low-power bit at 3 puts it in low-power during standby and sleep.
// RULE12: The first linear regulator switch-mode bit at 4 loads from fuses and may go from 0 to 1 but never back.
// RULE13: With switch mode 1 the first linear regulator is a fully-on switch, otherwise it regulates.
// RULE14: Configuration gives each linear regulator standby enable the same default as its run enable.
// RULE15: Unused upper bits read as zero and writes to them are ignored.
`timescale 1ns/1ps
module rcr_regs
#(
	parameter int ADDR_W = rcr_pkg::RCR_ADDR_W
)
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Avalon-MM slave, byte address
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic o_avs_waitrequest,
	output logic [31:0] o_avs_readdata,
	// Fuse defaults, taken while the load strobe is high
	input wire logic i_otp_load,
	input wire logic i_fused_memref_run,
	input wire logic i_fused_lr1_run,
	input wire logic i_fused_lr2_run,
	input wire logic [rcr_pkg::RCR_LR1_VOLT_W-1:0] i_fused_lr1_volt,
	input wire logic [rcr_pkg::RCR_LR2_VOLT_W-1:0] i_fused_lr2_volt,
	input wire logic i_fused_switch_mode_default,
	// Power-up sequencer, one-cycle pulses that switch a regulator on
	input wire logic i_seq_memref_on,
	input wire logic i_seq_lr1_on,
	input wire logic i_seq_lr2_on,
	// Power state from the state machine
	input wire logic i_standby,
	input wire logic i_sleep,
	// Regulator controls
	output logic o_memref_on,
	output logic o_memref_low_power,
	output logic o_lr1_on,
	output logic o_lr1_low_power,
	output logic o_lr1_switch_mode,
	output logic [rcr_pkg::RCR_LR1_VOLT_W-1:0] o_lr1_voltage_code,
	output logic o_lr2_on,
	output logic o_lr2_low_power,
	output logic [rcr_pkg::RCR_LR2_VOLT_W-1:0] o_lr2_voltage_code
);
	import rcr_pkg::*;

	if ((ADDR_W < RCR_ADDR_W) || (ADDR_W > 34))
	begin : g_addr_check
		$error("rcr_regs: ADDR_W outside the range the address decode serves");
	end

	// Bus handshake
	logic wr_stb;
	logic [7:0] rdata;

	rcr_avs_port rcr_avs_port_inst
	(
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_read(i_avs_read),
		.i_write(i_avs_write),
		.i_rdata(rdata),
		.o_waitrequest(o_avs_waitrequest),
		.o_readdata(o_avs_readdata),
		.o_wr_stb(wr_stb)
	);

	// Address decode: aligned word, index is byte address over four
	// Compare at 32 bits so the 256 bound survives wide address widths
	wire aligned = (i_avs_address[1:0] == 2'h0) &&
		(32'(i_avs_address[ADDR_W-1:2]) < 32'h0000_0100);
	wire [7:0] index = 8'(i_avs_address[ADDR_W-1:2]);
	wire hit_memref = aligned && (index == RCR_IDX_MEMREF_CTRL);
	wire hit_lr1_volt = aligned && (index == RCR_IDX_LR1_VOLT);
	wire hit_lr1_ctrl = aligned && (index == RCR_IDX_LR1_CTRL);
	wire hit_lr2_volt = aligned && (index == RCR_IDX_LR2_VOLT);
	wire hit_lr2_ctrl = aligned && (index == RCR_IDX_LR2_CTRL);
	// Only the low byte lane carries register bits
	wire wr_low = wr_stb & i_avs_byteenable[0];
	wire [4:0] wdata = i_avs_writedata[4:0];

	// Control registers, one slot per regulator
	logic [4:0] ctrl [RCR_N_CTRL];
	logic [4:0] next_ctrl [RCR_N_CTRL];
	wire [4:0] mask [RCR_N_CTRL];
	wire [4:0] fused [RCR_N_CTRL];
	wire hit_ctrl [RCR_N_CTRL];
	wire seq_on [RCR_N_CTRL];
	logic [RCR_N_CTRL-1:0] on_q;
	logic [RCR_N_CTRL-1:0] lp_q;

	assign mask[RCR_K_MEMREF] = RCR_MASK_MEMREF;
	assign mask[RCR_K_LR1] = RCR_MASK_LR1_CTRL;
	assign mask[RCR_K_LR2] = RCR_MASK_LR2_CTRL;
	// Standby default follows the fused run enable
	assign fused[RCR_K_MEMREF] = {3'h0, i_fused_memref_run, i_fused_memref_run}; // see RULE5
	assign fused[RCR_K_LR1] = {i_fused_switch_mode_default, 2'h0, i_fused_lr1_run,
		i_fused_lr1_run}; // see RULE14
	assign fused[RCR_K_LR2] = {3'h0, i_fused_lr2_run, i_fused_lr2_run}; // see RULE14
	assign hit_ctrl[RCR_K_MEMREF] = hit_memref;
	assign hit_ctrl[RCR_K_LR1] = hit_lr1_ctrl;
	assign hit_ctrl[RCR_K_LR2] = hit_lr2_ctrl;
	assign seq_on[RCR_K_MEMREF] = i_seq_memref_on;
	assign seq_on[RCR_K_LR1] = i_seq_lr1_on;
	assign seq_on[RCR_K_LR2] = i_seq_lr2_on;

	for (genvar k = 0; k < RCR_N_CTRL; k++)
	begin : g_ctrl
		// Ordinary bits take the written value; the set-only bit can only rise
		wire [4:0] wr_val = (wdata & mask[k] & ~RCR_MASK_SET_ONLY) |
			((ctrl[k] | wdata) & mask[k] & RCR_MASK_SET_ONLY); // see RULE12 RULE15
		wire [4:0] base = i_otp_load ? (fused[k] & mask[k]) :
			((wr_low && hit_ctrl[k]) ? wr_val : ctrl[k]); // see RULE8
		// Sequencer set wins over a software clear in the same cycle
		wire [4:0] seq_bit = seq_on[k] ? 5'h01 : 5'h00; // see RULE1 RULE8
		wire run = ctrl[k][RCR_BIT_RUN];
		wire stby_on = run & ctrl[k][RCR_BIT_STBY]; // see RULE2 RULE9
		wire sleep_on = run & ctrl[k][RCR_BIT_SLEEP]; // see RULE3 RULE10
		wire on_now = i_sleep ? sleep_on : (i_standby ? stby_on : run); // see RULE1 RULE8
		// Memory reference low-power applies at all times, linear ones only when resting
		wire lp_now = (k == RCR_K_MEMREF) ? ctrl[k][RCR_BIT_LP] :
			(ctrl[k][RCR_BIT_LP] & (i_standby | i_sleep)); // see RULE4 RULE11

		assign next_ctrl[k] = base | seq_bit;

		always_ff @(posedge i_sys_clk)
		begin
			if (!i_rst_n)
			begin
				ctrl[k] <= RCR_RST_CTRL;
				on_q[k] <= 1'b0;
				lp_q[k] <= 1'b0;
			end
			else
			begin
				ctrl[k] <= next_ctrl[k];
				on_q[k] <= on_now;
				lp_q[k] <= lp_now;
			end
		end
	end

	// Voltage code registers
	logic [RCR_LR1_VOLT_W-1:0] lr1_volt;
	logic [RCR_LR2_VOLT_W-1:0] lr2_volt;
	logic switch_q;
	wire [RCR_LR1_VOLT_W-1:0] next_lr1_volt = i_otp_load ? i_fused_lr1_volt :
		((wr_low && hit_lr1_volt) ? wdata[RCR_LR1_VOLT_W-1:0] : lr1_volt); // see RULE6
	wire [RCR_LR2_VOLT_W-1:0] next_lr2_volt = i_otp_load ? i_fused_lr2_volt :
		((wr_low && hit_lr2_volt) ? wdata[RCR_LR2_VOLT_W-1:0] : lr2_volt); // see RULE7

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			lr1_volt <= RCR_RST_VOLT[RCR_LR1_VOLT_W-1:0];
			lr2_volt <= RCR_RST_VOLT[RCR_LR2_VOLT_W-1:0];
			switch_q <= 1'b0;
		end
		else
		begin
			lr1_volt <= next_lr1_volt;
			lr2_volt <= next_lr2_volt;
			switch_q <= ctrl[RCR_K_LR1][RCR_BIT_SWITCH]; // see RULE13
		end
	end

	// Read mux; unmapped addresses and unused bits read as zero
	assign rdata = hit_memref ? {3'h0, ctrl[RCR_K_MEMREF]} :
		hit_lr1_volt ? {3'h0, lr1_volt} :
		hit_lr1_ctrl ? {3'h0, ctrl[RCR_K_LR1]} :
		hit_lr2_volt ? {4'h0, lr2_volt} :
		hit_lr2_ctrl ? {3'h0, ctrl[RCR_K_LR2]} : 8'h00; // see RULE15

	assign o_memref_on = on_q[RCR_K_MEMREF];
	assign o_memref_low_power = lp_q[RCR_K_MEMREF];
	assign o_lr1_on = on_q[RCR_K_LR1];
	assign o_lr1_low_power = lp_q[RCR_K_LR1];
	assign o_lr1_switch_mode = switch_q;
	assign o_lr1_voltage_code = lr1_volt;
	assign o_lr2_on = on_q[RCR_K_LR2];
	assign o_lr2_low_power = lp_q[RCR_K_LR2];
	assign o_lr2_voltage_code = lr2_volt;

endmodule // rcr_regs

// ### core/rcr_pkg.sv
// Package for the regulator control register bank.
// Assumes byte addressing on the register bus, one 32-bit word per register.
package rcr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] RCR_IDX_MEMREF_CTRL = 8'h4a;
	localparam logic [7:0] RCR_IDX_LR1_VOLT = 8'h4c;
	localparam logic [7:0] RCR_IDX_LR1_CTRL = 8'h4d;
	localparam logic [7:0] RCR_IDX_LR2_VOLT = 8'h4f;
	localparam logic [7:0] RCR_IDX_LR2_CTRL = 8'h50;
	localparam int RCR_ADDR_W = 9;

	// Control field positions; bits 0 to 3 common to all three control registers, the switch bit only in the first linear one
	localparam int RCR_BIT_RUN = 0;
	localparam int RCR_BIT_STBY = 1;
	localparam int RCR_BIT_SLEEP = 2;
	localparam int RCR_BIT_LP = 3;
	localparam int RCR_BIT_SWITCH = 4;

	// Implemented-bit masks
	localparam logic [4:0] RCR_MASK_MEMREF = 5'h0f;
	localparam logic [4:0] RCR_MASK_LR1_CTRL = 5'h1f;
	localparam logic [4:0] RCR_MASK_LR2_CTRL = 5'h0f;
	localparam logic [4:0] RCR_MASK_SET_ONLY = 5'h10;
	localparam int RCR_LR1_VOLT_W = 5;
	localparam int RCR_LR2_VOLT_W = 4;

	// Reset values
	localparam logic [4:0] RCR_RST_CTRL = 5'h00;
	localparam logic [4:0] RCR_RST_VOLT = 5'h00;

	// Control register slots
	localparam int RCR_N_CTRL = 3;
	localparam int RCR_K_MEMREF = 0;
	localparam int RCR_K_LR1 = 1;
	localparam int RCR_K_LR2 = 2;

endpackage

// ### core/rcr_avs_port.sv
// Avalon-MM slave handshake for the regulator control bank.
// Assumes the master holds address, read, write and writedata until waitrequest is low.
`timescale 1ns/1ps
module rcr_avs_port
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Bus request
	input wire logic i_read,
	input wire logic i_write,
	// Read data from the register decode
	input wire logic [7:0] i_rdata,
	// Bus answer
	output logic o_waitrequest,
	output logic [31:0] o_readdata,
	// Write commit strobe to the register file
	output logic o_wr_stb
);

	logic waitrequest;
	logic [31:0] readdata;
	wire req = i_read | i_write;
	// Answer on the cycle after a fresh request; drop back to waiting after the commit edge
	wire answer = req & waitrequest;
	wire commit = req & ~waitrequest;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end
		else
		begin
			waitrequest <= ~answer;
			readdata <= answer ? {24'h00_0000, i_rdata} : readdata;
		end
	end

	assign o_waitrequest = waitrequest;
	assign o_readdata = readdata;
	assign o_wr_stb = commit & i_write;

endmodule // rcr_avs_port

// ### bench/rcr_regs_assertions.sv
// Checker for the regulator control bank, bound onto rcr_regs.
// Assumes the one-wait-cycle bus answer and one-cycle output flops.
`timescale 1ns/1ps
module rcr_regs_assertions
#(
	parameter int ADDR_W = 9
)
(
	// Clock, reset, bus
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic o_avs_waitrequest,
	input wire logic [31:0] o_avs_readdata,
	// Control inputs and regulator outputs
	input wire logic i_otp_load,
	input wire logic i_seq_memref_on,
	input wire logic i_standby,
	input wire logic i_sleep,
	input wire logic o_memref_on,
	input wire logic o_memref_low_power,
	input wire logic o_lr1_low_power,
	input wire logic o_lr1_switch_mode,
	input wire logic [4:0] o_lr1_voltage_code,
	input wire logic [3:0] o_lr2_voltage_code
);
	wire logic cm = i_avs_write & !o_avs_waitrequest & i_avs_byteenable[0] & !i_otp_load;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	property p_wait_one; (i_avs_read | i_avs_write) & o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer late");
	property p_wait_short; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	a_wait_short: assert property (p_wait_short) else $error("answer too long");
	property p_rd_upper; o_avs_readdata[31:5] == 27'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	property p_mem_off; cm & i_avs_address == 9'h128 & !i_avs_writedata[0] & !i_seq_memref_on
		|-> ##2 !o_memref_on; endproperty
	a_mem_off: assert property (p_mem_off) else $error("reference stays on");
	property p_mem_lp; cm & i_avs_address == 9'h128
		|-> ##2 o_memref_low_power == $past(i_avs_writedata[3], 2); endproperty
	a_mem_lp: assert property (p_mem_lp) else $error("reference lp wrong");
	property p_lr1_lp; o_lr1_low_power |-> $past(i_standby | i_sleep); endproperty
	a_lr1_lp: assert property (p_lr1_lp) else $error("lp outside low states");
	property p_sw_keep; $fell(o_lr1_switch_mode) |-> $past(i_otp_load, 2) | $past(i_otp_load);
	endproperty
	a_sw_keep: assert property (p_sw_keep) else $error("switch mode cleared");
	property p_v1; cm & i_avs_address == 9'h130 |=> o_lr1_voltage_code == $past(i_avs_writedata[4:0]);
	endproperty
	a_v1: assert property (p_v1) else $error("lr1 code wrong");
	property p_v2; cm & i_avs_address == 9'h13c |=> o_lr2_voltage_code == $past(i_avs_writedata[3:0]);
	endproperty
	a_v2: assert property (p_v2) else $error("lr2 code wrong");
	c_write: cover property (cm);
	c_lp: cover property (i_standby & o_lr1_low_power);
	c_sw: cover property (o_lr1_switch_mode);
endmodule // rcr_regs_assertions
bind rcr_regs rcr_regs_assertions #(.ADDR_W(ADDR_W)) rcr_regs_assertions_inst (.*);

// ### bench/rcr_regs_test.sv
// Self-checking bench for the regulator control bank.
// Assumes rcr_regs answers every bus request after one wait cycle.
`timescale 1ns/1ps
module rcr_regs_test;
	typedef struct {logic [8:0] a; logic [31:0] d; logic [31:0] e;} rcr_row_s;
	logic clk = 1'b0, i_rst_n = 1'b0, rd = 1'b0, wr = 1'b0, ld = 1'b0, sq = 1'b0;
	logic sb = 1'b0, sl = 1'b0, fr = 1'b1, wt, m_on, m_lp, l1_on, l1_lp, sw, l2_on, l2_lp;
	logic fsw = 1'b0;
	logic [8:0] adr = 9'h000;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [4:0] f1v = 5'h15, v1;
	logic [3:0] f2v = 4'ha, v2;
	int bad_count = 0, total_checks = 0, cyc = 0;
	rcr_row_s rows [7] = '{'{9'h130, 32'hff, 32'h1f}, '{9'h130, 32'he0, 32'h00},
		'{9'h13c, 32'hff, 32'h0f}, '{9'h13c, 32'h10, 32'h00}, '{9'h128, 32'hf0, 32'h00},
		'{9'h140, 32'hf5, 32'h05}, '{9'h12c, 32'hff, 32'h00}};
	rcr_regs rcr_regs_inst (.i_sys_clk(clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_waitrequest(wt), .o_avs_readdata(rdat), .i_otp_load(ld), .i_fused_memref_run(fr),
		.i_fused_lr1_run(fr), .i_fused_lr2_run(fr), .i_fused_lr1_volt(f1v),
		.i_fused_lr2_volt(f2v), .i_fused_switch_mode_default(fsw), .i_seq_memref_on(1'b0),
		.i_seq_lr1_on(1'b0), .i_seq_lr2_on(sq), .i_standby(sb), .i_sleep(sl), .o_memref_on(m_on),
		.o_memref_low_power(m_lp), .o_lr1_on(l1_on), .o_lr1_low_power(l1_lp),
		.o_lr1_switch_mode(sw), .o_lr1_voltage_code(v1), .o_lr2_on(l2_on),
		.o_lr2_low_power(l2_lp), .o_lr2_voltage_code(v2));
	always #20 clk = ~clk;
	task end_of_test();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low
	task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wt !== 1'b0) @(posedge clk);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		i_rst_n <= 1'b1;
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			check(q, rows[i].e);
		end
		bus(1'b1, 9'h128, 32'h0b);
		bus(1'b1, 9'h134, 32'h0b);
		bus(1'b1, 9'h140, 32'h0b);
		for (int s = 0; s < 3; s++)
		begin
			sb <= (s == 1);
			sl <= (s == 2);
			repeat (3) @(posedge clk);
			check({m_on, l1_on, l2_on, m_lp, l1_lp, l2_lp}, {{3{s != 2}}, 1'b1, {2{s != 0}}});
		end
		sb <= 1'b0;
		sl <= 1'b0;
		bus(1'b1, 9'h134, 32'h1f);
		bus(1'b1, 9'h134, 32'h00);
		bus(1'b0, 9'h134, 32'h0);
		check(q, 32'h10);
		check({sw, l1_on}, 2'b10);
		bus(1'b1, 9'h140, 32'h0a);
		sq <= 1'b1;
		@(posedge clk);
		sq <= 1'b0;
		bus(1'b0, 9'h140, 32'h0);
		check(q, 32'h0b);
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		bus(1'b0, 9'h128, 32'h0);
		check(q[1:0], 2'b11);
		check({v1, v2}, {f1v, f2v});
		bus(1'b0, 9'h134, 32'h0);
		check(q, 32'h03);
		bus(1'b0, 9'h140, 32'h0);
		check(q, 32'h03);
		// Fused switch-mode default of 1 must reach the output
		fsw <= 1'b1;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		fsw <= 1'b0;
		repeat (2) @(posedge clk);
		check(sw, 1'b1);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		i_rst_n <= 1'b1;
		foreach (rows[i])
		begin
			bus(1'b0, rows[i].a, 32'h0);
			check(q, 32'h0);
		end
		check({m_on, l1_on, sw, v1}, 8'h00);
		end_of_test();
	end
endmodule // rcr_regs_test
